// *** hdl/dhrd_cfg.svh ***
// Constants for the disk host register decode block
`ifndef DHRD_CFG_SVH
`define DHRD_CFG_SVH

// Register addresses on DA(2:0)
`define DHRD_CTRL_DA 3'h6
`define DHRD_DEVHEAD_DA 3'h6
`define DHRD_CMD_DA 3'h7

// Field positions
`define DHRD_HOB_BIT 7
`define DHRD_SRST_BIT 2
`define DHRD_NIEN_BIT 1
`define DHRD_DEV_BIT 4

// Reset value and status read padding
`define DHRD_DEVHEAD_RST 8'h00
`define DHRD_STATUS_PAD 8'h00

// Command code of DEVICE RESET (plain default, override if needed)
`define DHRD_DEVRST_CODE 8'h08

// Pin vector layout after synchronisation
`define DHRD_PIN_W 24
`define DHRD_PIN_IDLE 24'hC70000
`define DHRD_P_CS0 23
`define DHRD_P_CS1 22
`define DHRD_P_DA_HI 21
`define DHRD_P_DA_LO 19
`define DHRD_P_DMACK 18
`define DHRD_P_RD 17
`define DHRD_P_WR 16

`endif

// *** hdl/dhrd_pin_if.sv ***
// Synchronised host pins and strobe edge pulses
interface dhrd_pin_if;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dmack_n;
    logic [15:0] dd;
    logic rd_go;
    logic rd_end;
    logic wr_go;
    logic wr_end;
    modport sync (output cs0_n, cs1_n, da, dmack_n, dd,
                  output rd_go, rd_end, wr_go, wr_end);
    modport core (input cs0_n, cs1_n, da, dmack_n, dd,
                  input rd_go, rd_end, wr_go, wr_end);
endinterface

// *** hdl/dhrd_pin_sync.sv ***
// Two-stage pin synchroniser with strobe edge detection
`include "dhrd_cfg.svh"
module dhrd_pin_sync
    import dhrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dmack_n,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic [15:0] dd_in,
    dhrd_pin_if.sync pins
);
    logic [`DHRD_PIN_W-1:0] meta;
    logic [`DHRD_PIN_W-1:0] stab;
    logic rd_prev;
    logic wr_prev;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta <= `DHRD_PIN_IDLE;
            stab <= `DHRD_PIN_IDLE;
        end else begin
            meta <= {cs0_n, cs1_n, da, dmack_n, dior_n, diow_n, dd_in};
            stab <= meta;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
        end else begin
            rd_prev <= stab[`DHRD_P_RD];
            wr_prev <= stab[`DHRD_P_WR];
        end
    end

    assign pins.cs0_n = stab[`DHRD_P_CS0];
    assign pins.cs1_n = stab[`DHRD_P_CS1];
    assign pins.da = stab[`DHRD_P_DA_HI:`DHRD_P_DA_LO];
    assign pins.dmack_n = stab[`DHRD_P_DMACK];
    assign pins.dd = stab[15:0];
    // One pulse per strobe edge, so each assertion is acted on once
    assign pins.rd_go = rd_prev & ~stab[`DHRD_P_RD];
    assign pins.rd_end = ~rd_prev & stab[`DHRD_P_RD];
    assign pins.wr_go = wr_prev & ~stab[`DHRD_P_WR];
    assign pins.wr_end = ~wr_prev & stab[`DHRD_P_WR];
endmodule

// *** hdl/dhrd_pkg.sv ***
// Types and decode function for the disk host register decode block
package dhrd_pkg;
`include "dhrd_cfg.svh"

    typedef enum logic [2:0] {
        SEL_NONE, SEL_CTRL, SEL_DEVHEAD, SEL_CMD, SEL_OTHER
    } dhrd_sel_e;

    typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} dhrd_acc_e;

    // Select and address to target register; illegal combinations give none
    function automatic dhrd_sel_e dhrd_decode(input logic cs0_n,
                                              input logic cs1_n,
                                              input logic [2:0] da);
        dhrd_sel_e s;
        s = SEL_NONE;
        if (!cs0_n && cs1_n) begin
            if (da == `DHRD_CMD_DA) begin
                s = SEL_CMD;
            end else if (da == `DHRD_DEVHEAD_DA) begin
                s = SEL_DEVHEAD;
            end else begin
                s = SEL_OTHER;
            end
        end else if (cs0_n && !cs1_n && da == `DHRD_CTRL_DA) begin
            s = SEL_CTRL;
        end
        return s;
    endfunction
endpackage

// *** hdl/dhrd_top.sv ***
// Host register decode of a parallel disk interface, device end
// Operation
// - Sleep control write updates only software reset
// - Sleep keeps DMA request released always
// - Sleep device/head write stores only select bit, and only with device reset implemented
// - Sleep command write ignored except device reset
// - Sleep ignores reads and other addresses
// - Invalid selects: bus released, strobes ignored
// - Control select valid only at address 6h
// - Selected when select bit equals device number
// - Control address reads alternate, writes control
// - Alternate status mirrors status, keeps interrupt
// - Command address reads return status
// - Sleep command ignored unless packet device reset
// - Command write starts, captures parameters, clears interrupt
// - Control block holds only control, alternate status
// - Device select at device/head bit 4
// - Software reset at control bit 2
`include "dhrd_cfg.svh"
module dhrd_top
    import dhrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic dmack_n,
    input wire logic [15:0] dd_in,
    output logic [15:0] dd_out,
    output logic dd_oe,
    output logic dmarq_out,
    output logic dmarq_oe,
    input wire logic sleep_mode,
    input wire logic dev_num,
    input wire logic devreset_impl,
    input wire logic [7:0] status_in,
    output logic srst,
    output logic nien,
    output logic hob,
    output logic [7:0] devhead,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic [7:0] param_devhead,
    output logic intrq_clear,
    output logic dev_reset_req
);
    dhrd_pin_if pins ();

    dhrd_pin_sync u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .cs0_n(cs0_n),
        .cs1_n(cs1_n),
        .da(da),
        .dmack_n(dmack_n),
        .dior_n(dior_n),
        .diow_n(diow_n),
        .dd_in(dd_in),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode at strobe assertion
    dhrd_acc_e acc;
    dhrd_sel_e acc_sel;
    dhrd_sel_e sel_now;
    logic selected;
    logic rd_ok;
    logic commit;
    logic [7:0] wdata;

    assign sel_now = dhrd_decode(pins.cs0_n, pins.cs1_n, pins.da);
    assign selected = (devhead[`DHRD_DEV_BIT] == dev_num);
    // Only status images are readable here; asleep nothing is
    assign rd_ok = !sleep_mode && selected
                   && (sel_now == SEL_CTRL || sel_now == SEL_CMD);
    assign commit = (acc == ACC_WRITE) && pins.wr_end;
    assign wdata = pins.dd[7:0];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc <= ACC_IDLE;
            acc_sel <= SEL_NONE;
        end else begin
            case (acc)
                ACC_IDLE: begin
                    if (pins.rd_go) begin
                        acc <= ACC_READ;
                        acc_sel <= sel_now;
                    end else if (pins.wr_go) begin
                        acc <= ACC_WRITE;
                        acc_sel <= sel_now;
                    end
                end
                ACC_READ: begin
                    if (pins.rd_end) begin
                        acc <= ACC_IDLE;
                    end
                end
                ACC_WRITE: begin
                    if (pins.wr_end) begin
                        acc <= ACC_IDLE;
                    end
                end
                default: begin
                    acc <= ACC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: both addresses show the same status image
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dd_oe <= 1'b0;
            dd_out <= 16'h0000;
        end else if (acc == ACC_IDLE && pins.rd_go && rd_ok) begin
            dd_oe <= 1'b1;
            dd_out <= {`DHRD_STATUS_PAD, status_in};
        end else if (acc != ACC_READ || pins.rd_end) begin
            dd_oe <= 1'b0;
        end
    end

    // No DMA engine here, so the request line stays released
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dmarq_out <= 1'b0;
            dmarq_oe <= 1'b0;
        end else begin
            dmarq_out <= 1'b0;
            dmarq_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Device Control, the only writable control block register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            srst <= 1'b0;
            nien <= 1'b0;
            hob <= 1'b0;
        end else if (commit && acc_sel == SEL_CTRL) begin
            srst <= wdata[`DHRD_SRST_BIT];
            if (!sleep_mode) begin
                nien <= wdata[`DHRD_NIEN_BIT];
                hob <= wdata[`DHRD_HOB_BIT];
            end
        end else if (commit && !sleep_mode && acc_sel != SEL_NONE) begin
            hob <= 1'b0;
        end
    end

    // Device/Head: both devices store it; asleep only DEV may change
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            devhead <= `DHRD_DEVHEAD_RST;
        end else if (commit && acc_sel == SEL_DEVHEAD) begin
            if (!sleep_mode) begin
                devhead <= wdata;
            end else if (devreset_impl) begin
                devhead[`DHRD_DEV_BIT] <= wdata[`DHRD_DEV_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command register and interrupt clear
    logic cmd_take;
    logic rst_take;
    assign cmd_take = commit && acc_sel == SEL_CMD && selected
                      && !sleep_mode;
    assign rst_take = commit && acc_sel == SEL_CMD && selected
                      && sleep_mode && devreset_impl
                      && wdata == `DHRD_DEVRST_CODE;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmd_strobe <= 1'b0;
            cmd_code <= 8'h00;
            param_devhead <= 8'h00;
        end else begin
            cmd_strobe <= cmd_take;
            if (cmd_take) begin
                cmd_code <= wdata;
                param_devhead <= devhead;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dev_reset_req <= 1'b0;
        end else begin
            dev_reset_req <= rst_take;
        end
    end

    // Status read and command write clear; alternate status read does not
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            intrq_clear <= 1'b0;
        end else begin
            intrq_clear <= cmd_take
                || (acc == ACC_IDLE && pins.rd_go && rd_ok
                    && sel_now == SEL_CMD);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic rd_start;
    assign rd_start = acc == ACC_IDLE && pins.rd_go;

    property p_dmarq_rel;
        @(posedge clk_sys) disable iff (reset)
        sleep_mode && pins.dmack_n |=> !dmarq_oe;
    endproperty
    a_dmarq_rel: assert property (p_dmarq_rel)
        else $error("request line driven in sleep");

    property p_sleep_ctrl;
        @(posedge clk_sys) disable iff (reset)
        sleep_mode && commit && acc_sel == SEL_CTRL |=>
            srst == $past(wdata[`DHRD_SRST_BIT]) && $stable(nien)
            && $stable(hob);
    endproperty
    a_sleep_ctrl: assert property (p_sleep_ctrl)
        else $error("sleep control write touched more than reset bit");

    property p_sleep_devhead;
        @(posedge clk_sys) disable iff (reset)
        sleep_mode && devreset_impl && commit && acc_sel == SEL_DEVHEAD
        |=> devhead[7:5] == $past(devhead[7:5])
            && devhead[3:0] == $past(devhead[3:0])
            && devhead[`DHRD_DEV_BIT] == $past(wdata[`DHRD_DEV_BIT]);
    endproperty
    a_sleep_devhead: assert property (p_sleep_devhead)
        else $error("sleep device/head write wrong");

    property p_sleep_cmd;
        @(posedge clk_sys) disable iff (reset)
        sleep_mode && commit && acc_sel == SEL_CMD |=>
            !cmd_strobe && (dev_reset_req == ($past(devreset_impl)
            && $past(selected) && $past(wdata) == `DHRD_DEVRST_CODE));
    endproperty
    a_sleep_cmd: assert property (p_sleep_cmd)
        else $error("sleep command write handled wrongly");

    property p_sleep_read;
        @(posedge clk_sys) disable iff (reset)
        rd_start && sleep_mode |=> !dd_oe [*2];
    endproperty
    a_sleep_read: assert property (p_sleep_read)
        else $error("read answered in sleep");

    property p_invalid;
        @(posedge clk_sys) disable iff (reset)
        rd_start && (pins.cs0_n == pins.cs1_n
            || (pins.cs0_n && pins.da != `DHRD_CTRL_DA)) |=> !dd_oe;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("bus driven on invalid address");

    property p_cmd_sel;
        @(posedge clk_sys) disable iff (reset)
        cmd_strobe |-> param_devhead[`DHRD_DEV_BIT] == dev_num
            && intrq_clear && param_devhead == devhead;
    endproperty
    a_cmd_sel: assert property (p_cmd_sel)
        else $error("command taken while not selected");

    property p_alt_read;
        @(posedge clk_sys) disable iff (reset)
        rd_start && rd_ok && sel_now == SEL_CTRL |=>
            dd_oe && dd_out[7:0] == $past(status_in) && !intrq_clear;
    endproperty
    a_alt_read: assert property (p_alt_read)
        else $error("alternate status read wrong");

    property p_stat_read;
        @(posedge clk_sys) disable iff (reset)
        rd_start && rd_ok && sel_now == SEL_CMD |=>
            dd_oe && dd_out[7:0] == $past(status_in) && intrq_clear;
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("command address read wrong");

    property p_release;
        @(posedge clk_sys) disable iff (reset)
        dd_oe && pins.rd_end |=> !dd_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("bus held after strobe release");

    c_cmd: cover property (@(posedge clk_sys) cmd_strobe);
    c_devrst: cover property (@(posedge clk_sys) dev_reset_req);
    c_alt: cover property (@(posedge clk_sys)
        rd_start && rd_ok && sel_now == SEL_CTRL);
    c_srst: cover property (@(posedge clk_sys) sleep_mode && srst);
endmodule

// *** test/dhrd_host_model.sv ***
// Host controller model driving selects, address and strobes
module dhrd_host_model (
    input wire logic clk_sys,
    input wire logic [15:0] dd_out,
    input wire logic dd_oe,
    output logic cs0_n = 1'b1,
    output logic cs1_n = 1'b1,
    output logic [2:0] da = 3'h0,
    output logic dior_n = 1'b1,
    output logic diow_n = 1'b1,
    output logic [15:0] dd_in = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;

    // One strobe cycle; setup and hold well above three clocks
    task automatic access(input logic is_rd, input logic c0, input logic c1,
                          input logic [2:0] a, input logic [7:0] d,
                          output logic oe, output logic [15:0] q);
        @(posedge clk_sys);
        cs0_n <= c0;
        cs1_n <= c1;
        da <= a;
        dd_in <= {~d, d};
        repeat (4) @(posedge clk_sys);
        if (is_rd) begin
            dior_n <= 1'b0;
        end else begin
            diow_n <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        oe = dd_oe;
        q = dd_out;
        dior_n <= 1'b1;
        diow_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        // Released lines must not keep the last value
        cs0_n <= 1'b1;
        cs1_n <= 1'b1;
        da <= ~a;
        dd_in <= ~dd_in;
    endtask
endmodule

// *** test/test_dhrd_top.sv ***
// Self-checking bench for the host register decode block
`include "dhrd_cfg.svh"
module test_dhrd_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] CT = 2'b10;
    localparam logic [1:0] CB = 2'b01;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sleep_mode = 1'b0;
    logic dev_num = 1'b1;
    logic devreset_impl = 1'b0;
    logic [7:0] status_in = 8'h50;
    logic dmack_n = 1'b1;
    logic cs0_n, cs1_n, dior_n, diow_n, dd_oe, dmarq_out, dmarq_oe;
    logic srst, nien, hob, cmd_strobe, intrq_clear, dev_reset_req, oe_s;
    logic [2:0] da;
    logic [15:0] dd_in, dd_out, q_s;
    logic [7:0] devhead, cmd_code, param_devhead;
    int err_total = 0;
    int checks_done = 0;
    int n_cmd = 0;
    int n_clr = 0;
    int n_rst = 0;

    dhrd_top DUT (.clk_sys, .reset, .cs0_n, .cs1_n, .da, .dior_n, .diow_n,
        .dmack_n, .dd_in, .dd_out, .dd_oe, .dmarq_out, .dmarq_oe,
        .sleep_mode, .dev_num, .devreset_impl, .status_in, .srst, .nien,
        .hob, .devhead, .cmd_strobe, .cmd_code, .param_devhead,
        .intrq_clear, .dev_reset_req);
    dhrd_host_model HOST (.clk_sys, .dd_out, .dd_oe, .cs0_n, .cs1_n, .da,
        .dior_n, .diow_n, .dd_in);

    always #5 clk_sys = ~clk_sys;

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pulses are one cycle wide, so count them as they pass
    always @(posedge clk_sys) begin
        n_cmd <= n_cmd + int'(cmd_strobe === 1'b1);
        n_clr <= n_clr + int'(intrq_clear === 1'b1);
        n_rst <= n_rst + int'(dev_reset_req === 1'b1);
        if (sleep_mode && !reset) chk_bit(dmarq_oe | dmarq_out, 1'b0);
    end

    task automatic wr(input logic [1:0] cs, input logic [2:0] a,
                      input logic [7:0] d);
        HOST.access(1'b0, cs[1], cs[0], a, d, oe_s, q_s);
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [1:0] cs, input logic [2:0] a,
                      input logic exp_oe);
        HOST.access(1'b1, cs[1], cs[0], a, 8'h00, oe_s, q_s);
        @(posedge clk_sys);
        #1;
        chk_bit(oe_s, exp_oe);
        if (exp_oe) begin
            chk_byte(q_s[7:0], status_in);
            chk_byte(q_s[15:8], 8'h00);
        end
    endtask

    task automatic t_ctrl;
        int c;
        chk_byte(devhead, `DHRD_DEVHEAD_RST);
        wr(CT, `DHRD_CTRL_DA, 8'h86);
        chk_bit(srst, 1'b1);
        chk_bit(nien, 1'b1);
        chk_bit(hob, 1'b1);
        // Reset leaves device 0 selected; this one is device 1
        rd(CT, `DHRD_CTRL_DA, 1'b0);
        wr(CB, `DHRD_DEVHEAD_DA, 8'h10);
        c = n_clr;
        rd(CT, `DHRD_CTRL_DA, 1'b1);
        chk_n(n_clr, c);
        wr(CT, `DHRD_CTRL_DA, 8'h00);
        chk_bit(srst, 1'b0);
        $display("test ctrl done");
    endtask

    task automatic t_invalid;
        logic [1:0] cs [5] = '{2'b00, 2'b11, 2'b10, 2'b10, 2'b10};
        logic [2:0] ad [5] = '{3'h6, 3'h6, 3'h7, 3'h5, 3'h0};
        for (int i = 0; i < 5; i++) begin
            wr(cs[i], ad[i], 8'h04);
            chk_bit(srst, 1'b0);
            rd(cs[i], ad[i], 1'b0);
        end
        $display("test invalid done");
    endtask

    task automatic t_cmd;
        int c0;
        int c1;
        wr(CT, `DHRD_CTRL_DA, 8'h80);
        wr(CB, `DHRD_DEVHEAD_DA, 8'h10);
        chk_byte(devhead, 8'h10);
        chk_bit(hob, 1'b0);
        c0 = n_cmd;
        c1 = n_clr;
        wr(CB, `DHRD_CMD_DA, 8'hEC);
        chk_n(n_cmd, c0 + 1);
        chk_byte(cmd_code, 8'hEC);
        chk_byte(param_devhead, 8'h10);
        chk_n(n_clr, c1 + 1);
        rd(CB, `DHRD_CMD_DA, 1'b1);
        chk_n(n_clr, c1 + 2);
        wr(CB, `DHRD_DEVHEAD_DA, 8'h00);
        wr(CB, `DHRD_CMD_DA, 8'h20);
        chk_n(n_cmd, c0 + 1);
        $display("test command done");
    endtask

    task automatic t_sleep;
        int c;
        int c1;
        wr(CT, `DHRD_CTRL_DA, 8'h02);
        @(posedge clk_sys);
        sleep_mode <= 1'b1;
        wr(CT, `DHRD_CTRL_DA, 8'h84);
        chk_bit(srst, 1'b1);
        chk_bit(nien, 1'b1);
        chk_bit(hob, 1'b0);
        wr(CT, `DHRD_CTRL_DA, 8'h00);
        chk_bit(srst, 1'b0);
        rd(CT, `DHRD_CTRL_DA, 1'b0);
        wr(CB, `DHRD_DEVHEAD_DA, 8'hFF);
        chk_byte(devhead, 8'h00);
        c = n_rst;
        c1 = n_cmd;
        wr(CB, `DHRD_CMD_DA, `DHRD_DEVRST_CODE);
        chk_n(n_rst, c);
        @(posedge clk_sys);
        devreset_impl <= 1'b1;
        wr(CB, `DHRD_DEVHEAD_DA, 8'hFF);
        chk_byte(devhead, 8'h10);
        wr(CB, `DHRD_CMD_DA, 8'hEC);
        chk_n(n_rst, c);
        wr(CB, `DHRD_CMD_DA, `DHRD_DEVRST_CODE);
        chk_n(n_rst, c + 1);
        chk_n(n_cmd, c1);
        wr(CB, 3'h2, 8'h55);
        rd(CB, `DHRD_CMD_DA, 1'b0);
        chk_byte(devhead, 8'h10);
        @(posedge clk_sys);
        dev_num <= 1'b0;
        wr(CB, `DHRD_CMD_DA, `DHRD_DEVRST_CODE);
        chk_n(n_rst, c + 1);
        $display("test sleep done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // About thirty accesses of some twenty cycles each
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        results();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_ctrl();
        t_invalid();
        t_cmd();
        t_sleep();
        results();
    end
endmodule
